// *** ubg_uart.sv ***
`timescale 1ns/1ns
module ubg_uart #(
   parameter logic [15:0] DIV_INIT = ubg_pkg::DIV_RESET
) (
   input logic i_clk,          // System clock, 50 MHz
   input logic i_rst_n,        // Async reset, active low
   input logic [11:0] i_addr,  // Register address
   input logic [7:0] i_wdata,  // Write data
   input logic i_wr,           // Write strobe
   input logic i_rd,           // Read strobe
   output logic [7:0] o_rdata, // Read data, cycle after read
   input logic i_serial_in,    // Serial input pin
   input logic i_cts_n,        // Clear to send, active low
   output logic o_serial_out,  // Serial output pin
   output logic o_rx_irq       // Receive or timer interrupt
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [15:0] div;
      logic [7:0] tx_hold;
      logic tx_full;
      ubg_pkg::ubg_phase_e tx_st;
      logic [8:0] tx_sh;
      logic [3:0] tx_sub;
      logic [2:0] tx_bit;
      logic tx_out;
      ubg_pkg::ubg_phase_e rx_st;
      logic [3:0] rx_sub;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_ninth;
      logic [7:0] rx_data;
      logic rx_available_flag;
      logic pe;
      logic oe;
      logic fe;
      logic brk;
      logic frame_start_flag;
      logic last_ninth_bit;
      logic ov_pend;
      logic brk_pend;
      logic frm_pend;
      logic [7:0] rdata;
      logic irq;
   } ubg_state_s;
   ubg_state_s r;
   ubg_state_s n;
   logic [1:0] sync_q;
   logic rx_in;
   logic cts_lvl;
   logic tick;
   logic [15:0] div_count;
   logic div_reload;
   logic rd_data;
   logic wr_data;
   logic rx_done;
   logic tx_idle;
   logic timer_mode;
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] reg_addr);
      hit = (a == reg_addr);
   endfunction : hit
   // Even parity of a byte, inverted for odd parity
   function automatic logic par(input logic [7:0] d, input logic odd);
      par = (^d) ^ odd;
   endfunction : par

   // ----------------------------------------------------------------
   // Pin synchronisers and bit-rate divider
   // ----------------------------------------------------------------
   ubg_sync2 #(
      .W(2)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_d({i_cts_n, i_serial_in}),
      .o_q(sync_q)
   );

   assign rx_in = sync_q[0];
   assign cts_lvl = sync_q[1];
   assign div_reload = i_wr && (hit(i_addr, ubg_pkg::ADDR_DIV_HI) ||
                                hit(i_addr, ubg_pkg::ADDR_DIV_LO));

   ubg_divider #(
      .WIDTH(16)
   ) u_div (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_divisor(n.div),
      .i_reload(div_reload),
      .o_count(div_count),
      .o_tick(tick)
   );
   assign rd_data = i_rd && hit(i_addr, ubg_pkg::ADDR_DATA);
   assign wr_data = i_wr && hit(i_addr, ubg_pkg::ADDR_DATA);
   assign tx_idle = (r.tx_st == ubg_pkg::PH_IDLE) && !r.tx_full;
   // Software must clear the receive enable before arming the timer
   assign timer_mode = r.ctl1[ubg_pkg::C1_DIVIDER_TIMER_CONTROL] &&
                       !r.ctl0[ubg_pkg::C0_REN];
   assign rx_done = tick && r.ctl0[ubg_pkg::C0_REN] &&
                    (r.rx_st == ubg_pkg::PH_STOP) &&
                    (r.rx_sub == ubg_pkg::TICK_LAST);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic has9;
      logic brk_c;
      logic pe_c;
      logic tx9;
      has9 = 1'b0;
      brk_c = 1'b0;
      pe_c = 1'b0;
      tx9 = 1'b0;
      n = r;
      has9 = r.ctl0[ubg_pkg::C0_PEN] || r.ctl1[ubg_pkg::C1_MPEN];
      // Control writes
      if (i_wr) begin
         if (hit(i_addr, ubg_pkg::ADDR_CTL0)) begin
            n.ctl0 = i_wdata;
         end else if (hit(i_addr, ubg_pkg::ADDR_CTL1)) begin
            n.ctl1 = i_wdata;
         end else if (hit(i_addr, ubg_pkg::ADDR_DIV_HI)) begin
            n.div[15:8] = i_wdata;
         end else if (hit(i_addr, ubg_pkg::ADDR_DIV_LO)) begin
            n.div[7:0] = i_wdata;
         end
      end
      // Transmitter
      tx9 = r.ctl1[ubg_pkg::C1_MPEN] ? r.ctl1[ubg_pkg::C1_MPBT] :
            par(r.tx_hold, r.ctl0[ubg_pkg::C0_PSEL]);
      if (r.tx_st == ubg_pkg::PH_IDLE) begin
         if (r.tx_full && r.ctl0[ubg_pkg::C0_TEN]) begin
            n.tx_sh = {tx9, r.tx_hold};
            n.tx_full = 1'b0;
            n.tx_st = ubg_pkg::PH_START;
            n.tx_sub = 4'h0;
         end
      end else if (tick) begin
         n.tx_sub = r.tx_sub + 4'h1;
         if (r.tx_sub == ubg_pkg::TICK_LAST) begin
            case (r.tx_st)
               ubg_pkg::PH_START: begin
                  n.tx_st = ubg_pkg::PH_DATA;
                  n.tx_bit = 3'h0;
               end
               ubg_pkg::PH_DATA: begin
                  n.tx_sh = {1'b1, r.tx_sh[8:1]};
                  n.tx_bit = r.tx_bit + 3'h1;
                  if (r.tx_bit == ubg_pkg::BIT_LAST) begin
                     n.tx_st = has9 ? ubg_pkg::PH_NINTH :
                               ubg_pkg::PH_STOP;
                  end
               end
               ubg_pkg::PH_NINTH: begin
                  n.tx_st = ubg_pkg::PH_STOP;
               end
               default: begin
                  n.tx_st = ubg_pkg::PH_IDLE;
               end
            endcase
         end
      end
      // A write always wins; it fills the holding stage
      if (wr_data) begin
         n.tx_hold = i_wdata;
         n.tx_full = 1'b1;
      end
      case (n.tx_st)
         ubg_pkg::PH_START: n.tx_out = 1'b0;
         ubg_pkg::PH_DATA: n.tx_out = n.tx_sh[0];
         ubg_pkg::PH_NINTH: n.tx_out = n.tx_sh[0];
         default: n.tx_out = 1'b1;
      endcase
      // Receiver
      if (!r.ctl0[ubg_pkg::C0_REN]) begin
         n.rx_st = ubg_pkg::PH_IDLE;
      end else if (tick) begin
         n.rx_sub = r.rx_sub + 4'h1;
         case (r.rx_st)
            ubg_pkg::PH_IDLE: begin
               if (!rx_in) begin
                  n.rx_st = ubg_pkg::PH_START;
                  n.rx_sub = 4'h0;
                  n.rx_ninth = 1'b0;
               end
            end
            ubg_pkg::PH_START: begin
               // Re-check at mid start bit to reject glitches
               if (r.rx_sub == ubg_pkg::TICK_MID) begin
                  n.rx_st = rx_in ? ubg_pkg::PH_IDLE :
                            ubg_pkg::PH_DATA;
                  n.rx_sub = 4'h0;
                  n.rx_bit = 3'h0;
               end
            end
            ubg_pkg::PH_DATA: begin
               if (r.rx_sub == ubg_pkg::TICK_LAST) begin
                  n.rx_sh = {rx_in, r.rx_sh[7:1]};
                  n.rx_bit = r.rx_bit + 3'h1;
                  if (r.rx_bit == ubg_pkg::BIT_LAST) begin
                     n.rx_st = has9 ? ubg_pkg::PH_NINTH :
                               ubg_pkg::PH_STOP;
                  end
               end
            end
            ubg_pkg::PH_NINTH: begin
               if (r.rx_sub == ubg_pkg::TICK_LAST) begin
                  n.rx_ninth = rx_in;
                  n.rx_st = ubg_pkg::PH_STOP;
               end
            end
            default: begin
               if (r.rx_sub == ubg_pkg::TICK_LAST) begin
                  n.rx_st = ubg_pkg::PH_IDLE;
               end
            end
         endcase
      end
      // Data read clears the receive flags first
      if (rd_data) begin
         if (!r.rx_available_flag) begin
            n.oe = 1'b0;
         end
         n.rx_available_flag = 1'b0;
         n.pe = 1'b0;
         n.fe = 1'b0;
         n.brk = 1'b0;
         n.frame_start_flag = 1'b0;
         n.last_ninth_bit = 1'b0;
         if (r.ov_pend) begin
            n.oe = 1'b1;
            n.brk = r.brk_pend;
            n.rx_available_flag = 1'b1;
            n.ov_pend = 1'b0;
         end
      end

      // Completion comes after the clear, so a new event is never lost
      brk_c = (r.rx_sh == 8'h00) && !r.rx_ninth && !rx_in;
      pe_c = r.ctl0[ubg_pkg::C0_PEN] && !r.ctl1[ubg_pkg::C1_MPEN] &&
             (par(r.rx_sh, r.rx_ninth) != r.ctl0[ubg_pkg::C0_PSEL]);
      if (rx_done) begin
         if (n.rx_available_flag) begin
            // Held byte is kept; overrun and break wait for its read
            n.ov_pend = 1'b1;
            n.brk_pend = brk_c;
         end else begin
            n.rx_data = r.rx_sh;
            n.rx_available_flag = 1'b1;
            n.pe = pe_c;
            n.fe = !rx_in;
            n.brk = brk_c;
            n.last_ninth_bit = r.ctl1[ubg_pkg::C1_MPEN] && r.rx_ninth;
            if (r.ctl1[ubg_pkg::C1_MPEN] && r.rx_ninth) begin
               n.frm_pend = 1'b1;
               n.frame_start_flag = 1'b0;
            end else begin
               n.frame_start_flag = r.frm_pend;
               n.frm_pend = 1'b0;
            end
         end
      end

      // Timer reloads share the receive interrupt line
      n.irq = (tick && timer_mode) || rx_done;

      // Read data, valid only in the cycle after the strobe
      n.rdata = 8'h00;
      if (i_rd) begin
         if (hit(i_addr, ubg_pkg::ADDR_DATA)) begin
            n.rdata = r.rx_data;
         end else if (hit(i_addr, ubg_pkg::ADDR_LSTAT)) begin
            n.rdata = {r.rx_available_flag, r.pe, r.oe, r.fe, r.brk,
                       !r.tx_full, tx_idle, cts_lvl};
         end else if (hit(i_addr, ubg_pkg::ADDR_CTL0)) begin
            n.rdata = r.ctl0;
         end else if (hit(i_addr, ubg_pkg::ADDR_CTL1)) begin
            n.rdata = r.ctl1;
         end else if (hit(i_addr, ubg_pkg::ADDR_FSTAT)) begin
            n.rdata = {6'h00, r.frame_start_flag, r.last_ninth_bit};
         end else if (hit(i_addr, ubg_pkg::ADDR_DIV_HI)) begin
            // No high-byte latch: the two reads may straddle a borrow
            n.rdata = r.ctl1[ubg_pkg::C1_DIVIDER_TIMER_CONTROL] ? div_count[15:8] :
                      r.div[15:8];
         end else if (hit(i_addr, ubg_pkg::ADDR_DIV_LO)) begin
            n.rdata = r.ctl1[ubg_pkg::C1_DIVIDER_TIMER_CONTROL] ? div_count[7:0] :
                      r.div[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
         r.ctl0 <= ubg_pkg::CTL_RESET;
         r.ctl1 <= ubg_pkg::CTL_RESET;
         r.div <= DIV_INIT;
         r.tx_st <= ubg_pkg::PH_IDLE;
         r.rx_st <= ubg_pkg::PH_IDLE;
         r.tx_sh <= 9'h1FF;
         r.tx_out <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign o_rdata = r.rdata;
   assign o_serial_out = r.tx_out;
   assign o_rx_irq = r.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_rd_data;
      i_rd && (i_addr == ubg_pkg::ADDR_DATA);
   endsequence
   sequence s_wr_data;
      i_wr && (i_addr == ubg_pkg::ADDR_DATA);
   endsequence
   sequence s_rd_lstat;
      i_rd && (i_addr == ubg_pkg::ADDR_LSTAT);
   endsequence

   AST_TX_HOLDING_EMPTY_FLAG_CLR:
   assert property (s_wr_data |=> r.tx_full)
      else $error("holding empty flag not cleared by write");
   AST_RDA_CLR:
   assert property (s_rd_data ##0 (!rx_done && !r.ov_pend) |=> !r.rx_available_flag)
      else $error("receive available not cleared by read");
   AST_OE_KEEP:
   assert property (s_rd_data ##0 (r.rx_available_flag && r.oe) |=> r.oe)
      else $error("overrun cleared while byte was available");
   AST_RX_HOLD:
   assert property (rx_done && r.rx_available_flag && !rd_data
      |=> $stable(r.rx_data) && r.ov_pend)
      else $error("held byte overwritten on overrun");
   AST_CTS:
   assert property (s_rd_lstat |=> o_rdata[0] == $past(cts_lvl))
      else $error("status bit 0 not the handshake level");
   AST_TXE:
   assert property (s_rd_lstat ##0 (r.tx_st != ubg_pkg::PH_IDLE)
      |=> !o_rdata[ubg_pkg::LS_TXE])
      else $error("shifter idle shown while shifting");
   AST_START_LOW:
   assert property (r.tx_st == ubg_pkg::PH_START |-> !o_serial_out)
      else $error("start bit not low");
   AST_TIMER:
   assert property (tick && timer_mode |=> o_rx_irq)
      else $error("timer reload gave no interrupt");
   AST_SUB_HOLD:
   assert property (r.tx_st != ubg_pkg::PH_IDLE && !tick
      |=> $stable(r.tx_sub))
      else $error("bit timing advanced without a tick");
endmodule : ubg_uart

// *** ubg_pkg.sv ***
// Notes on behaviour
// - Bit rate comes from system clock divided by a 16-bit two-byte divisor.
// - Bit rate is clock over sixteen times divisor; a bit spans sixteen ticks.
// - With the port disabled the divider works as a 16-bit interrupting timer.
// - Timer interrupt interval equals clock period times the divisor value.
// - A byte written at the data address is shifted out the serial pin.
// - Each received byte lands in the read-only receive holding register unless a byte there is still unread.
// - Receive-available flag is set while a byte waits; data read clears it.
// - Parity fault flag is set on parity mismatch; data read clears it.
// - Overrun set when the held byte is read after an unread arrival; data read clears it only if available is 0.
// - Framing fault flag is set on missing stop bit; data read clears it.
// - Line break flag is set on an all-zero character; data read clears it.
// - Holding-empty flag shows room for a byte; a data write clears it.
// - Shifter-idle flag is 1 only when nothing waits and nothing is shifting.
// - Status bit 0 returns the live clear-to-send level.
// - Frame-start flag marks the first data byte of a frame; data read clears.
// - Last ninth bit returns the last character's ninth bit in multiprocessor mode; data read clears.
// - With timer control set and receive disabled, every divider tick raises the receive interrupt.
// - On overrun keep the held byte; show overrun and break after it is read.
// - With timer control set, divisor reads return the live count, unlatched.
package ubg_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_DATA = 12'hF40;
   localparam logic [11:0] ADDR_LSTAT = 12'hF41;
   localparam logic [11:0] ADDR_CTL0 = 12'hF42;
   localparam logic [11:0] ADDR_CTL1 = 12'hF43;
   localparam logic [11:0] ADDR_FSTAT = 12'hF44;
   localparam logic [11:0] ADDR_DIV_HI = 12'hF46;
   localparam logic [11:0] ADDR_DIV_LO = 12'hF47;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int LS_RDA = 7;
   localparam int LS_PE = 6;
   localparam int LS_OE = 5;
   localparam int LS_FE = 4;
   localparam int LS_BRK = 3;
   localparam int LS_TX_HOLDING_EMPTY_FLAG = 2;
   localparam int LS_TXE = 1;
   localparam int LS_CTS = 0;
   localparam int C0_TEN = 7;
   localparam int C0_REN = 6;
   localparam int C0_PEN = 4;
   localparam int C0_PSEL = 3;
   localparam int C1_MPEN = 6;
   localparam int C1_MPBT = 4;
   localparam int C1_DIVIDER_TIMER_CONTROL = 2;
   // ----------------------------------------------------------------
   // Reset values and timing counts
   // ----------------------------------------------------------------
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [15:0] DIV_RESET = 16'h0001;
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // ----------------------------------------------------------------
   // Bit phases of a character, shared by transmitter and receiver
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      PH_IDLE = 5'h01,
      PH_START = 5'h02,
      PH_DATA = 5'h04,
      PH_NINTH = 5'h08,
      PH_STOP = 5'h10
   } ubg_phase_e;
endpackage : ubg_pkg

// *** ubg_sync2.sv ***
`timescale 1ns/1ns
module ubg_sync2 #(
   parameter int W = 2
) (
   input logic i_clk,          // System clock
   input logic i_rst_n,        // Async reset, active low
   input logic [W-1:0] i_d,    // Asynchronous levels
   output logic [W-1:0] o_q    // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } ubg_sync_s;

   ubg_sync_s r;
   ubg_sync_s n;

   always_comb begin
      n.meta = i_d;
      n.q = r.meta;
   end

   // Idle line and negated handshake both rest high
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '1;
      end else begin
         r <= n;
      end
   end

   assign o_q = r.q;
endmodule : ubg_sync2

// *** ubg_divider.sv ***
`timescale 1ns/1ns
module ubg_divider #(
   parameter int WIDTH = 16
) (
   input logic i_clk,                // System clock
   input logic i_rst_n,              // Async reset, active low
   input logic [WIDTH-1:0] i_divisor,// Reload value
   input logic i_reload,             // Restart from divisor
   output logic [WIDTH-1:0] o_count, // Live count
   output logic o_tick               // End of period
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } ubg_div_s;

   ubg_div_s r;
   ubg_div_s n;

   // A zero divisor behaves as one: a tick every clock
   assign o_tick = (r.count <= WIDTH'(1));

   always_comb begin
      n = r;
      if (i_reload || o_tick) begin
         n.count = i_divisor;
      end else begin
         n.count = r.count - WIDTH'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r.count <= WIDTH'(1);
      end else begin
         r <= n;
      end
   end

   assign o_count = r.count;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   AST_RELOAD:
   assert property (o_tick && !i_reload |=> r.count == $past(i_divisor))
      else $error("divider did not reload after tick");
   AST_TICK_GAP:
   assert property (o_tick && !i_reload && i_divisor > WIDTH'(1)
      |=> !o_tick)
      else $error("divider ticked twice in a row");
endmodule : ubg_divider

// *** ubg_peer.sv ***
`timescale 1ns/1ns
// -------------------------------------------------------------
// Remote serial station: sends frames and collects bytes
// -------------------------------------------------------------
module ubg_peer #(
   parameter int BP = 32
) (
   input logic i_clk,         // System clock
   input logic i_line,        // Line driven by the block
   output logic o_line,       // Line into the block
   output logic [7:0] o_byte, // Last byte heard
   output int o_count         // Bytes heard so far
);
   initial begin
      o_line = 1'b1;
      o_byte = 8'h00;
      o_count = 0;
   end
   // Bit 0 of f is the start bit; the line idles high after the frame
   task send(input logic [10:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk) o_line <= f[i];
         repeat (BP - 1) @(posedge i_clk);
      end
      @(posedge i_clk) o_line <= 1'b1;
   endtask : send
   // Mid-bit sampling tolerates the short first start-bit tick
   initial begin
      forever begin
         @(negedge i_line);
         repeat (BP / 2) @(posedge i_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BP) @(posedge i_clk);
            o_byte[i] = i_line;
         end
         repeat (BP) @(posedge i_clk);
         o_count = o_count + 1;
      end
   end
endmodule : ubg_peer

// *** tb_ubg_uart.sv ***
`timescale 1ns/1ns
module tb_ubg_uart;
   // Small divisor keeps each bit at 32 clocks
   localparam logic [15:0] DIV = 16'h0002;
   localparam int BP = 32;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [11:0] i_addr = 12'h000;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_cts_n = 1'b1;
   logic [7:0] o_rdata, v, w, pbyte;
   logic o_serial_out, o_rx_irq, line_in;
   int failures = 0, n_checks = 0, n_irq = 0, cyc = 0, pcnt;

   always #10 i_clk = ~i_clk;

   ubg_uart #(.DIV_INIT(DIV)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .i_serial_in(line_in), .i_cts_n(i_cts_n),
      .o_serial_out(o_serial_out), .o_rx_irq(o_rx_irq));
   ubg_peer #(.BP(BP)) peer (.i_clk(i_clk), .i_line(o_serial_out),
      .o_line(line_in), .o_byte(pbyte), .o_count(pcnt));

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   task end_sim;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // A hang costs at most this many cycles
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (o_rx_irq === 1'b1) n_irq <= n_irq + 1;
      if (cyc == 30000) begin
         failures = failures + 1;
         end_sim;
      end
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task done(input string s);
      $display("%s finished, failures %0d", s, failures);
   endtask : done
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task rd(input logic [11:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd
   task put(input logic [10:0] f, input int n);
      peer.send(f, n);
      repeat (8) @(posedge i_clk);
   endtask : put
   task wait_cnt(input int n);
      for (int i = 0; i < 4000 && pcnt < n; i++) @(posedge i_clk);
   endtask : wait_cnt

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task t_reset;
      wr(12'hF41, 8'hFF);
      rd(12'hF41, v); chk(v, 8'h07);
      rd(12'hF44, v); chk(v, 8'h00);
      rd(12'hF46, v); chk(v, 8'h00);
      rd(12'hF47, v); chk(v, DIV[7:0]);
      rd(12'h000, v); chk(v, 8'h00);
      @(posedge i_clk) i_cts_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      rd(12'hF41, v); chk(v, 8'h06);
      @(posedge i_clk) i_cts_n <= 1'b1;
      done("reset");
   endtask : t_reset
   task t_tx;
      wr(12'hF42, 8'h80);
      wr(12'hF40, 8'hA5);
      wr(12'hF40, 8'h3C);
      rd(12'hF41, v); chk(v, 8'h01);
      wait_cnt(1); chk(pbyte, 8'hA5);
      wait_cnt(2); chk(pbyte, 8'h3C);
      repeat (BP) @(posedge i_clk);
      rd(12'hF41, v); chk(v, 8'h07);
      wr(12'hF42, 8'h00);
      done("tx");
   endtask : t_tx
   task t_rx;
      wr(12'hF42, 8'h40);
      w = 8'(n_irq);
      put({2'b01, 8'h3C, 1'b0}, 10);
      chk(8'(n_irq) - w, 8'h01);
      rd(12'hF41, v); chk(v, 8'h87);
      rd(12'hF40, v); chk(v, 8'h3C);
      rd(12'hF41, v); chk(v, 8'h07);
      done("rx");
   endtask : t_rx
   task t_par;
      wr(12'hF42, 8'h50);
      put({2'b11, 8'h3C, 1'b0}, 11);
      rd(12'hF41, v); chk(v, 8'hC7);
      rd(12'hF40, v); chk(v, 8'h3C);
      rd(12'hF41, v); chk(v, 8'h07);
      done("parity");
   endtask : t_par
   task t_fault;
      wr(12'hF42, 8'h40);
      put({2'b00, 8'h55, 1'b0}, 10);
      rd(12'hF41, v); chk(v, 8'h97);
      rd(12'hF40, v); chk(v, 8'h55);
      put(11'h000, 10);
      rd(12'hF41, v); chk(v, 8'h9F);
      rd(12'hF40, v); chk(v, 8'h00);
      rd(12'hF41, v); chk(v, 8'h07);
      done("faults");
   endtask : t_fault
   task t_ovr;
      put({2'b01, 8'h11, 1'b0}, 10);
      put({2'b01, 8'h22, 1'b0}, 10);
      rd(12'hF41, v); chk(v, 8'h87);
      rd(12'hF40, v); chk(v, 8'h11);
      rd(12'hF41, v); chk(v, 8'hA7);
      rd(12'hF40, v);
      rd(12'hF41, v); chk(v, 8'h27);
      rd(12'hF40, v);
      rd(12'hF41, v); chk(v, 8'h07);
      done("overrun");
   endtask : t_ovr
   task t_ninth;
      wr(12'hF43, 8'h40);
      put({2'b11, 8'h81, 1'b0}, 11);
      rd(12'hF44, v); chk(v, 8'h01);
      rd(12'hF40, v); chk(v, 8'h81);
      rd(12'hF44, v); chk(v, 8'h00);
      put({2'b10, 8'h42, 1'b0}, 11);
      rd(12'hF44, v); chk(v, 8'h02);
      rd(12'hF40, v); chk(v, 8'h42);
      rd(12'hF44, v); chk(v, 8'h00);
      wr(12'hF43, 8'h00);
      done("ninth");
   endtask : t_ninth
   task t_timer;
      int n;
      n = 0;
      wr(12'hF42, 8'h00);
      wr(12'hF46, 8'h00);
      wr(12'hF47, 8'h05);
      wr(12'hF43, 8'h04);
      for (int i = 0; i < 100 && o_rx_irq !== 1'b1; i++) begin
         @(posedge i_clk);
         #1;
      end
      do begin
         @(posedge i_clk);
         #1 n++;
      end while (o_rx_irq !== 1'b1 && n < 100);
      chk(8'(n), 8'h05);
      rd(12'hF47, v);
      rd(12'hF47, w);
      chk({7'h00, v !== w}, 8'h01);
      wr(12'hF43, 8'h00);
      done("timer");
   endtask : t_timer

   initial begin
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      t_reset;
      t_tx;
      t_rx;
      t_par;
      t_fault;
      t_ovr;
      t_ninth;
      t_timer;
      end_sim;
   end
endmodule : tb_ubg_uart
